/* hdl/sbsa_core.sv */
// access control of a flow-through burst sram with common data pins
// Function
// - every synchronous pin is captured in an input register on the rising edge
// - order strap low gives linear, high or floating gives interleaved order
// - two-bit wraparound counter keeps the burst start and yields later addresses
// - counter loads from address bits one and zero and changes only those
// - burst address steps only when the burst step input is low
// - interleaved order visits the start offset xor the step count
// - linear order adds the step count to the start offset modulo four
// - byte write gate with lane selects writes only the selected lanes
// - global write overrides lane selects and writes all four lanes
// - processor strobe is ignored while the first chip select is high
// - both strobes with all chip selects start a read; controller read needs writes idle
// - read latches address and counter and drives data in the same cycle
// - processor strobe start ignores write controls; write happens on the next edge
// - controller strobe with write controls active starts a one-cycle write
// - controller strobe is ignored when the processor strobe and the first chip select are both low
// - a detected write floats the data pins whatever output enable says
// - sleep request enters a low-power state that keeps the contents
// - entering and leaving sleep each take two clock cycles
// - accesses pending at sleep entry are dropped and are not valid
// - a write is global write low or gate low with any lane selected
// - with strobes idle and step high the current address is accessed again
// - first cycle out of the deselected state keeps the data pins floating
module sbsa_core
  import sbsa_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int LANES  = LANES_DEF
)
(
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire logic [ADDR_W-1:0]       addr,
  input  wire logic [LANES*BYTE_W-1:0] dq_in,
  output logic      [LANES*BYTE_W-1:0] dq_out,
  output logic                         dq_oe,
  input  wire logic [LANES-1:0]        lane_parity_bits_in,
  output logic      [LANES-1:0]        lane_parity_bits_out,
  output logic                         lane_parity_bits_oe,
  input  wire logic                    chip_sel_first_n,
  input  wire logic                    chip_sel_second,
  input  wire logic                    chip_sel_third_n,
  input  wire logic                    cpu_addr_strobe_n,
  input  wire logic                    ctrl_addr_strobe_n,
  input  wire logic                    burst_step_n,
  input  wire logic                    byte_write_gate_n,
  input  wire logic [LANES-1:0]        byte_lane_sel_n,
  input  wire logic                    all_bytes_write_n,
  input  wire logic                    out_enable_n,
  input  wire logic                    sleep_request,
  input  wire logic                    burst_order_strap,
  output logic                         sleep_active
);

  import sbsa_pkg::*;

  // ****************************************************************
  // input registers
  // ****************************************************************
  logic [ADDR_W-1:0]       a_q;
  logic [LANES*BYTE_W-1:0] din_q;
  logic [LANES-1:0]        par_q;
  logic                    cs1n_q;
  logic                    cs2_q;
  logic                    cs3n_q;
  logic                    cpun_q;
  logic                    ctrln_q;
  logic                    stepn_q;
  logic                    bwen_q;
  logic [LANES-1:0]        lanen_q;
  logic                    gwn_q;

  // all synchronous pins sampled together; strobes reset to idle
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      a_q     <= '0;
      din_q   <= '0;
      par_q   <= '0;
      cs1n_q  <= 1'b1;
      cs2_q   <= 1'b0;
      cs3n_q  <= 1'b1;
      cpun_q  <= 1'b1;
      ctrln_q <= 1'b1;
      stepn_q <= 1'b1;
      bwen_q  <= 1'b1;
      lanen_q <= '1;
      gwn_q   <= 1'b1;
    end
    else
    begin
      a_q     <= addr;
      din_q   <= dq_in;
      par_q   <= lane_parity_bits_in;
      cs1n_q  <= chip_sel_first_n;
      cs2_q   <= chip_sel_second;
      cs3n_q  <= chip_sel_third_n;
      cpun_q  <= cpu_addr_strobe_n;
      ctrln_q <= ctrl_addr_strobe_n;
      stepn_q <= burst_step_n;
      bwen_q  <= byte_write_gate_n;
      lanen_q <= byte_lane_sel_n;
      gwn_q   <= all_bytes_write_n;
    end
  end

  // ****************************************************************
  // synchronisers for the asynchronous pins
  // ****************************************************************
  // bit 0 output enable, bit 1 sleep, bit 2 order strap
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic       order_q;
  logic       oe_n_s;
  logic       sleep_s;

  // output enable costs two cycles of latency here, the price of a clean crossing
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_q  <= 3'h5;
      sync_q  <= 3'h5;
      order_q <= ORDER_RST;
    end
    else
    begin
      meta_q  <= {burst_order_strap, sleep_request, out_enable_n};
      sync_q  <= meta_q;
      order_q <= sync_q[2];
    end
  end

  assign oe_n_s  = sync_q[0];
  assign sleep_s = sync_q[1];

  // ****************************************************************
  // cycle decode
  // ****************************************************************
  logic             sel_all;
  logic             wr_req;
  logic [LANES-1:0] lane_we;
  logic             cpu_seen;
  logic             ctrl_seen;

  // chip selects, write qualification and strobe priority
  always_comb
  begin
    sel_all   = !cs1n_q && cs2_q && !cs3n_q;
    wr_req    = !gwn_q || (!bwen_q && !(&lanen_q));
    lane_we   = '0;
    if (!gwn_q)
    begin
      lane_we = '1;
    end
    else if (!bwen_q)
    begin
      lane_we = ~lanen_q;
    end
    cpu_seen  = !cpun_q && !cs1n_q;
    ctrl_seen = !ctrln_q && (cpun_q || cs1n_q);
  end

  // ****************************************************************
  // access state, burst counter and address register
  // ****************************************************************
  sbsa_state_t              st_q;
  sbsa_state_t              st_d;
  logic [ADDR_W-1:BURST_W]  base_q;
  logic [ADDR_W-1:BURST_W]  base_d;
  logic [BURST_W-1:0]       start_q;
  logic [BURST_W-1:0]       start_d;
  logic [BURST_W-1:0]       cnt_q;
  logic [BURST_W-1:0]       cnt_d;
  logic [1:0]               zz_cnt_q;
  logic [1:0]               zz_cnt_d;
  logic                     rd_en;
  logic                     out_ok;
  logic [LANES-1:0]         mem_we;
  logic [BURST_W-1:0]       offs;
  logic [ADDR_W-1:0]        mem_addr;

  // one decision per edge; the address used is built from the next-state values
  always_comb
  begin
    st_d     = st_q;
    base_d   = base_q;
    start_d  = start_q;
    cnt_d    = cnt_q;
    zz_cnt_d = zz_cnt_q;
    rd_en    = 1'b0;
    out_ok   = 1'b0;
    mem_we   = '0;
    case (st_q)
      ST_DESEL, ST_BURST:
      begin
        if (sleep_s)
        begin
          st_d     = ST_ZZ_IN;
          zz_cnt_d = SLEEP_ENTER_LOAD;
        end
        else if (cpu_seen || ctrl_seen)
        begin
          if (sel_all)
          begin
            st_d    = ST_BURST;
            base_d  = a_q[ADDR_W-1:BURST_W];
            start_d = a_q[BURST_W-1:0];
            cnt_d   = BURST_CNT_RST;
            if (ctrl_seen && wr_req)
            begin
              mem_we = lane_we;
            end
            else
            begin
              rd_en  = 1'b1;
              out_ok = 1'b1;
            end
          end
          else
          begin
            st_d = ST_DESEL;
          end
        end
        else if (st_q == ST_BURST)
        begin
          if (!stepn_q)
          begin
            cnt_d = cnt_q + BURST_STEP;
          end
          if (wr_req)
          begin
            mem_we = lane_we;
          end
          else
          begin
            rd_en  = 1'b1;
            out_ok = 1'b1;
          end
        end
      end
      ST_ZZ_IN:
      begin
        if (zz_cnt_q == 2'h0)
        begin
          st_d = ST_ZZ;
        end
        else
        begin
          zz_cnt_d = zz_cnt_q - 2'h1;
        end
      end
      ST_ZZ:
      begin
        if (!sleep_s)
        begin
          st_d     = ST_ZZ_OUT;
          zz_cnt_d = SLEEP_EXIT_LOAD;
        end
      end
      ST_ZZ_OUT:
      begin
        // strobes are not looked at while recovering
        if (sleep_s)
        begin
          st_d = ST_ZZ;
        end
        else if (zz_cnt_q == 2'h0)
        begin
          st_d = ST_DESEL;
        end
        else
        begin
          zz_cnt_d = zz_cnt_q - 2'h1;
        end
      end
      default:
      begin
        st_d = ST_DESEL;
      end
    endcase
    // interleaved order xors the step count in, linear order adds it
    if (order_q == ORDER_INTERLEAVED)
    begin
      offs = start_d ^ cnt_d;
    end
    else
    begin
      offs = start_d + cnt_d;
    end
    mem_addr = {base_d, offs};
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q     <= ST_DESEL;
      base_q   <= '0;
      start_q  <= BURST_CNT_RST;
      cnt_q    <= BURST_CNT_RST;
      zz_cnt_q <= 2'h0;
    end
    else
    begin
      st_q     <= st_d;
      base_q   <= base_d;
      start_q  <= start_d;
      cnt_q    <= cnt_d;
      zz_cnt_q <= zz_cnt_d;
    end
  end

  // ****************************************************************
  // output drive and sleep status
  // ****************************************************************
  logic oe_q;
  logic oe_d;
  logic sleep_q;
  logic sleep_d;

  // pins float on writes, in the first cycle out of deselect, and asleep
  always_comb
  begin
    oe_d    = out_ok && !oe_n_s && (st_q != ST_DESEL) && (mem_we == '0);
    sleep_d = (st_d == ST_ZZ);
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      oe_q    <= 1'b0;
      sleep_q <= 1'b0;
    end
    else
    begin
      oe_q    <= oe_d;
      sleep_q <= sleep_d;
    end
  end

  assign dq_oe               = oe_q;
  assign lane_parity_bits_oe = oe_q;
  assign sleep_active        = sleep_q;

  // ****************************************************************
  // storage and lane packing
  // ****************************************************************
  logic [LANES*LANE_W-1:0] wdata;
  logic [LANES*LANE_W-1:0] rdata;

  sbsa_store #(
    .ADDR_W (ADDR_W),
    .LANES  (LANES)
  ) u_store (
    .clk        (clk),
    .nrst       (nrst),
    .rd_en      (rd_en),
    .wr_lane_en (mem_we),
    .addr       (mem_addr),
    .wdata      (wdata),
    .rdata      (rdata)
  );

  // each lane holds its byte with its parity bit on top
  always_comb
  begin
    for (int i = 0; i < LANES; i++)
    begin
      wdata[i*LANE_W +: LANE_W]   = {par_q[i], din_q[i*BYTE_W +: BYTE_W]};
      dq_out[i*BYTE_W +: BYTE_W]  = rdata[i*LANE_W +: BYTE_W];
      lane_parity_bits_out[i]     = rdata[i*LANE_W + BYTE_W];
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  logic active_ok;
  assign active_ok = ((st_q == ST_DESEL) || (st_q == ST_BURST)) && !sleep_s;

  chk_write_floats: assert property (@(posedge clk) disable iff (!nrst)
    (mem_we != '0) |=> !dq_oe)
    else $error("data pins driven after a write");

  chk_cpu_ignored_cs1: assert property (@(posedge clk) disable iff (!nrst)
    (active_ok && !cpun_q && cs1n_q && ctrln_q && st_q == ST_DESEL) |=> st_q == ST_DESEL)
    else $error("processor strobe acted with first select high");

  chk_cpu_start_read: assert property (@(posedge clk) disable iff (!nrst)
    (active_ok && cpu_seen && sel_all) |-> (mem_we == '0 && rd_en))
    else $error("processor strobe start did not read");

  chk_burst_step: assert property (@(posedge clk) disable iff (!nrst)
    (active_ok && st_q == ST_BURST && cpun_q && ctrln_q && !stepn_q)
    |=> cnt_q == $past(cnt_q) + BURST_STEP)
    else $error("burst counter did not step");

  chk_burst_hold: assert property (@(posedge clk) disable iff (!nrst)
    (active_ok && st_q == ST_BURST && cpun_q && ctrln_q && stepn_q)
    |=> (cnt_q == $past(cnt_q) && st_q == ST_BURST))
    else $error("suspended burst moved");

  chk_sleep_entry: assert property (@(posedge clk) disable iff (!nrst)
    ($rose(sleep_s) && active_ok == 1'b0 && $past(active_ok)) ##1 sleep_s |=> sleep_active)
    else $error("sleep not entered within two cycles");

  chk_sleep_exit: assert property (@(posedge clk) disable iff (!nrst)
    ($fell(sleep_s) && st_q == ST_ZZ) ##1 !sleep_s |=> (st_q == ST_DESEL && !sleep_active))
    else $error("sleep not left within two cycles");

  chk_global_write: assert property (@(posedge clk) disable iff (!nrst)
    (!gwn_q && mem_we != '0) |-> mem_we == '1)
    else $error("global write missed a lane");

  chk_desel_float: assert property (@(posedge clk) disable iff (!nrst)
    (st_q == ST_DESEL) |=> !dq_oe)
    else $error("pins driven in first cycle after deselect");

  // a step from the last offset must come back to the start and never touch the upper bits
  chk_burst_wrap: assert property (@(posedge clk) disable iff (!nrst)
    (active_ok && st_q == ST_BURST && cpun_q && ctrln_q && !stepn_q && (&cnt_q))
    |=> (cnt_q == BURST_CNT_RST && start_q == $past(start_q) && base_q == $past(base_q)))
    else $error("burst did not wrap to its start");

endmodule : sbsa_core

/* shared/sbsa_pkg.sv */
// shared constants and types for the synchronous burst sram access block
package sbsa_pkg;

  // ****************************************************************
  // word layout
  // ****************************************************************
  localparam int ADDR_W_DEF  = 20;            // word address width, one mega-word
  localparam int LANES_DEF   = 4;             // byte lanes per word
  localparam int BYTE_W      = 8;             // data bits per lane
  localparam int LANE_W      = BYTE_W + 1;    // data bits plus one parity bit per lane
  localparam int BURST_W     = 2;             // width of the wraparound burst offset

  // ****************************************************************
  // burst order strap and reset values
  // ****************************************************************
  localparam logic ORDER_LINEAR      = 1'b0;  // strap low selects linear order
  localparam logic ORDER_INTERLEAVED = 1'b1;  // strap high or floating
  localparam logic ORDER_RST         = ORDER_INTERLEAVED;
  localparam logic [1:0] BURST_CNT_RST = 2'h0;
  localparam logic [1:0] BURST_STEP    = 2'h1;

  // ****************************************************************
  // sleep timing, in clock cycles
  // ****************************************************************
  localparam int SLEEP_ENTER_CYC = 2;
  localparam int SLEEP_EXIT_CYC  = 2;
  localparam logic [1:0] SLEEP_ENTER_LOAD = 2'(SLEEP_ENTER_CYC - 2);
  localparam logic [1:0] SLEEP_EXIT_LOAD  = 2'(SLEEP_EXIT_CYC - 2);

  // ****************************************************************
  // access state
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_DESEL,
    ST_BURST,
    ST_ZZ_IN,
    ST_ZZ,
    ST_ZZ_OUT
  } sbsa_state_t;

endpackage : sbsa_pkg

/* hdl/sbsa_store.sv */
// storage array with per-lane write enables and registered read data
module sbsa_store
  import sbsa_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int LANES  = LANES_DEF
)
(
  input  wire logic                      clk,
  input  wire logic                      nrst,
  input  wire logic                      rd_en,
  input  wire logic [LANES-1:0]          wr_lane_en,
  input  wire logic [ADDR_W-1:0]         addr,
  input  wire logic [LANES*LANE_W-1:0]   wdata,
  output logic      [LANES*LANE_W-1:0]   rdata
);

  // ****************************************************************
  // array
  // ****************************************************************
  // no reset on the array: contents survive sleep and are never cleared
  logic [LANES*LANE_W-1:0] mem_q [2**ADDR_W];
  logic [LANES*LANE_W-1:0] rdata_q;
  logic [LANES*LANE_W-1:0] rdata_d;

  // only the enabled lanes are written
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < LANES; i++)
    begin
      if (wr_lane_en[i])
      begin
        mem_q[addr][i*LANE_W +: LANE_W] <= wdata[i*LANE_W +: LANE_W];
      end
    end
  end

  // read data holds between reads; a suspend reads the same address again, so the pins stay steady
  always_comb
  begin
    rdata_d = rdata_q;
    if (rd_en)
    begin
      rdata_d = mem_q[addr];
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_q <= '0;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;

endmodule : sbsa_store

/* bench/sbsa_host.sv */
// requester model that drives the sram access pins and resolves the shared data wires
module sbsa_host
#(
  parameter int ADDR_W = 6
)
(
  input  wire logic              clk,
  input  wire logic [35:0]       dev_word,
  input  wire logic              dev_oe,
  output logic      [35:0]       bus_word,
  output logic      [ADDR_W-1:0] addr,
  output logic                   chip_sel_first_n,
  output logic                   chip_sel_second,
  output logic                   chip_sel_third_n,
  output logic                   cpu_addr_strobe_n,
  output logic                   ctrl_addr_strobe_n,
  output logic                   burst_step_n,
  output logic                   byte_write_gate_n,
  output logic      [3:0]        byte_lane_sel_n,
  output logic                   all_bytes_write_n,
  output logic                   out_enable_n,
  output logic                   sleep_request
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [35:0] wdata;
  logic        wr_intent;
  logic        host_drv;
  logic [35:0] last_q = 36'h0;

  // ********
  // shared wires
  // ********
  // drive only with output enable off and the device let go, so the wires never fight
  assign host_drv = wr_intent & out_enable_n & ~dev_oe;
  // no keeper on the wires: a floating wire shows the inverse of its last level
  assign bus_word = dev_oe ? dev_word : (host_drv ? wdata : ~last_q);
  always @(posedge clk) last_q <= bus_word;

  // ********
  // pin tasks
  // ********
  // one cycle of pins, called right after the falling edge
  task automatic drive(input logic [2:0] cs, input logic [2:0] st, input logic [1:0] wr,
                       input logic [3:0] ln, input logic [ADDR_W-1:0] a, input logic [35:0] d);
    {chip_sel_first_n, chip_sel_second, chip_sel_third_n} = cs;
    {cpu_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n} = st;
    {all_bytes_write_n, byte_write_gate_n} = wr;
    byte_lane_sel_n = ln;
    addr = a;
    wdata = d;
    wr_intent = ~wr[1] | (~wr[0] & ~&ln);
  endtask : drive

  // selects and strobes idle before sleep rises and while it recovers
  task automatic nap(input logic on);
    drive(3'b101, 3'b111, 2'b11, 4'hF, '0, '0);
    sleep_request = on;
  endtask : nap

  task automatic set_oe(input logic v);
    out_enable_n = v;
  endtask : set_oe

  initial
  begin
    out_enable_n = 1'b1;
    sleep_request = 1'b0;
    drive(3'b101, 3'b101, 2'b11, 4'hF, '0, '0);
  end
endmodule : sbsa_host

/* bench/sbsa_core_test.sv */
// self-checking testbench of the burst sram access core against a requester model
module sbsa_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  import sbsa_pkg::*;

  localparam int AW = 6;
  localparam logic [2:0]  SEL = 3'b010;
  localparam logic [2:0]  DES = 3'b101;
  localparam logic [38:0] OE0 = {3'b010, 36'h0};
  logic clk, nrst, strap, dq_oe, par_oe, sleep_active;
  logic chip_sel_first_n, chip_sel_second, chip_sel_third_n, cpu_addr_strobe_n, ctrl_addr_strobe_n;
  logic burst_step_n, byte_write_gate_n, all_bytes_write_n, out_enable_n, sleep_request;
  logic [3:0]    byte_lane_sel_n, par_out;
  logic [AW-1:0] addr;
  logic [31:0]   dq_out;
  logic [35:0]   bus_word, salt;
  logic [35:0]   ref_mem [64];
  logic [38:0]   expq [$];
  int            err_count, comparisons;

  sbsa_core #(.ADDR_W(AW)) i_dut (.clk, .nrst, .addr, .dq_in(bus_word[31:0]), .dq_out, .dq_oe,
    .lane_parity_bits_in(bus_word[35:32]), .lane_parity_bits_out(par_out), .lane_parity_bits_oe(par_oe),
    .chip_sel_first_n, .chip_sel_second, .chip_sel_third_n, .cpu_addr_strobe_n, .ctrl_addr_strobe_n,
    .burst_step_n, .byte_write_gate_n, .byte_lane_sel_n, .all_bytes_write_n, .out_enable_n,
    .sleep_request, .burst_order_strap(strap), .sleep_active);
  sbsa_host #(.ADDR_W(AW)) i_host (.clk, .dev_word({par_out, dq_out}), .dev_oe(dq_oe), .bus_word, .addr,
    .chip_sel_first_n, .chip_sel_second, .chip_sel_third_n, .cpu_addr_strobe_n, .ctrl_addr_strobe_n,
    .burst_step_n, .byte_write_gate_n, .byte_lane_sel_n, .all_bytes_write_n, .out_enable_n, .sleep_request);

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ********
  // helpers
  // ********
  task automatic cmp_w(input logic [35:0] got, input logic [35:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_w

  task automatic cmp_b(input logic got, input logic exp);
    cmp_w({35'h0, got}, {35'h0, exp});
  endtask : cmp_b

  function automatic logic [35:0] pat(input logic [AW-1:0] a);
    return {4'(a), 8'hC3, 2'b0, a, 8'h5A, 2'b0, ~a} ^ salt;
  endfunction : pat

  // expectation: check data, check enable, enable level, word
  function automatic logic [38:0] rd(input logic [AW-1:0] a, input logic oe);
    return {2'b11, oe, ref_mem[a]};
  endfunction : rd

  // a result shows two falling edges after its pins, so checks trail the stimulus by two calls
  task automatic cyc(input logic [2:0] cs, input logic [2:0] st, input logic [1:0] wr,
                     input logic [3:0] ln, input logic [AW-1:0] a, input logic [38:0] e);
    logic [38:0] x;
    @(negedge clk);
    if (expq.size() == 2)
    begin
      x = expq.pop_front();
      if (x[37]) cmp_w({dq_oe, par_oe}, {2{x[36]}});
      if (x[38]) cmp_w({par_out, dq_out}, x[35:0]);
      if (x[38] && x[36]) cmp_w(bus_word, x[35:0]);
    end
    expq.push_back(e);
    i_host.drive(cs, st, wr, ln, a, pat(a));
  endtask : cyc

  // deselect for two cycles so the pipeline drains
  task automatic flush();
    repeat (2) cyc(DES, 3'b101, 2'b11, 4'hF, '0, '0);
    expq.delete();
  endtask : flush

  task automatic chk3(input logic [AW-1:0] a0, input logic [AW-1:0] a1, input logic [AW-1:0] a2);
    cyc(SEL, 3'b101, 2'b11, 4'hF, a0, rd(a0, 1'b0));
    cyc(SEL, 3'b101, 2'b11, 4'hF, a1, rd(a1, 1'b0));
    cyc(SEL, 3'b101, 2'b11, 4'hF, a2, rd(a2, 1'b0));
    flush();
  endtask : chk3

  // ********
  // scenarios
  // ********
  task automatic t_fill();
    i_host.set_oe(1'b1);
    repeat (3) @(negedge clk);
    for (int a = 0; a < 64; a++)
    begin
      ref_mem[a] = pat(AW'(a));
      cyc(SEL, 3'b101, 2'b00, 4'h5, AW'(a), OE0);
    end
    flush();
    $display("fill done");
  endtask : t_fill

  // upper address bits nonzero and address pins scrambled while the burst continues
  task automatic t_burst(input logic ord);
    logic [AW-1:0] b, n;
    logic [1:0]    c;
    strap = ord;
    i_host.set_oe(1'b0);
    repeat (4) @(negedge clk);
    for (int s = 0; s < 4; s++)
    begin
      b = AW'(36 + s);
      cyc(SEL, 3'b101, 2'b11, 4'hF, b, rd(b, 1'b0));
      for (int i = 1; i < 6; i++)
      begin
        c = 2'((i < 3) ? i : i - 1);
        n = {b[AW-1:2], (ord == ORDER_INTERLEAVED) ? (b[1:0] ^ c) : (b[1:0] + c)};
        cyc(DES, {2'b11, i == 3}, 2'b11, 4'hF, ~b, rd(n, 1'b1));
      end
      flush();
    end
    $display("burst order %0d done", ord);
  endtask : t_burst

  task automatic t_float();
    cyc(SEL, 3'b101, 2'b11, 4'hF, 6'h30, rd(6'h30, 1'b0));
    cyc(DES, 3'b110, 2'b11, 4'hF, 6'h00, rd(6'h31, 1'b1));
    cyc(DES, 3'b111, 2'b01, 4'hF, 6'h00, OE0);
    ref_mem[49] = 'x;
    flush();
    $display("float done");
  endtask : t_float

  task automatic t_byte();
    i_host.set_oe(1'b1);
    repeat (3) @(negedge clk);
    salt = 36'h9_6969_6969;
    cyc(SEL, 3'b101, 2'b10, 4'hA, 6'h08, OE0);
    ref_mem[8] = (ref_mem[8] & ~36'h5_00FF_00FF) | (pat(6'h08) & 36'h5_00FF_00FF);
    cyc(SEL, 3'b101, 2'b10, 4'hF, 6'h09, rd(6'h09, 1'b0));
    cyc(SEL, 3'b101, 2'b11, 4'h0, 6'h0A, rd(6'h0A, 1'b0));
    flush();
    chk3(6'h08, 6'h09, 6'h0A);
    $display("byte done");
  endtask : t_byte

  task automatic t_cpu();
    salt = 36'h3_0F0F_0F0F;
    // processor strobe from deselect with the first select high: no read, old data holds
    cyc(3'b110, 3'b011, 2'b11, 4'hF, 6'h18, rd(6'h0A, 1'b0));
    cyc(SEL, 3'b011, 2'b01, 4'hF, 6'h10, rd(6'h10, 1'b0));
    ref_mem[17] = pat(6'h11);
    cyc(DES, 3'b110, 2'b01, 4'hF, 6'h11, OE0);
    cyc(SEL, 3'b001, 2'b01, 4'hF, 6'h14, rd(6'h14, 1'b0));
    cyc(3'b110, 3'b011, 2'b11, 4'hF, 6'h18, rd(6'h14, 1'b0));
    flush();
    chk3(6'h10, 6'h11, 6'h14);
    $display("strobe done");
  endtask : t_cpu

  task automatic t_sleep();
    @(negedge clk);
    i_host.nap(1'b1);
    repeat (3) @(negedge clk);
    cmp_b(sleep_active, 1'b0);
    @(negedge clk);
    cmp_b(sleep_active, 1'b1);
    repeat (4) @(negedge clk);
    i_host.nap(1'b0);
    repeat (2) @(negedge clk);
    cmp_b(sleep_active, 1'b1);
    repeat (2) @(negedge clk);
    cmp_b(sleep_active, 1'b0);
    repeat (2) @(negedge clk);
    chk3(6'h11, 6'h08, 6'h28);
    $display("sleep done");
  endtask : t_sleep

  task automatic summarize();
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  initial
  begin
    nrst = 1'b0;
    strap = ORDER_INTERLEAVED;
    salt = 36'h0;
    err_count = 0;
    comparisons = 0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    t_fill();
    t_burst(ORDER_INTERLEAVED);
    t_burst(ORDER_LINEAR);
    t_float();
    t_byte();
    t_cpu();
    t_sleep();
    summarize();
  end

  // the whole run needs well under a thousand cycles
  initial
  begin
    #200us;
    err_count++;
    $display("watchdog expired at %0t", $time);
    summarize();
  end
endmodule : sbsa_core_test
